/* File: rtl/rtc_flags_defs.vh */
// Purpose: constants for the rtc flag and control register block
// Assumes: 50 MHz system clock
// Notes:   offsets are byte addresses on the memory bus
`ifndef RTC_FLAGS_DEFS_VH
`define RTC_FLAGS_DEFS_VH
`define RTC_FLAG_CTRL_ADDR   19'h7FFF0
`define FLD_WATCHDOG         7
`define FLD_ALARM            6
`define FLD_POWER_DROP       5
`define FLD_OSC_STOPPED      4
`define FLD_CAL              2
`define FLD_WRITE_FREEZE     1
`define FLD_READ_FREEZE      0
`define RTC_FLAG_RESET       8'h00
`define OSC_CHECK_TIME_US    5000
`define CLK_MHZ              50
`define OSC_CHECK_CYCLES     (`OSC_CHECK_TIME_US * `CLK_MHZ)
`define CAL_FREQ_HZ          512
`define CLK_HZ               50000000
`define CAL_HALF_CYCLES      (`CLK_HZ / (2 * `CAL_FREQ_HZ))
`endif

/* File: rtl/bus_sync.v */
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: one clock domain
// Notes:   first stage is read only by the second stage
`timescale 1ns/100ps
module bus_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_sys,
  input  wire             rst_b,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] d_async,
  output reg  [WIDTH-1:0] q_sync
);
  reg [WIDTH-1:0] stage1_reg;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stage1_reg <= {WIDTH{1'b0}};
      q_sync     <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      stage1_reg <= d_async;
      q_sync     <= stage1_reg;
    end
  end
endmodule

/* File: rtl/cal_wave_gen.v */
// Purpose: 512 Hz calibration square wave from the system clock
// Assumes: 50 MHz clock
// Notes:   phase restarts whenever calibration is off
`timescale 1ns/100ps
`include "rtc_flags_defs.vh"
module cal_wave_gen (
  input  wire clk_sys,
  input  wire rst_b,
  input  wire clk_en,
  input  wire run,
  output reg  wave
);
  localparam integer HALF_INT = `CAL_HALF_CYCLES;
  localparam [15:0]  HALF     = HALF_INT[15:0];
  reg [15:0] count_reg;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= 16'h0000;
      wave      <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        count_reg <= 16'h0000;
        wave      <= 1'b0;
      end else if (count_reg == HALF - 16'h0001) begin
        count_reg <= 16'h0000;
        wave      <= ~wave;
      end else begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end
endmodule

/* File: rtl/rtc_flags_control_register.v */
// Purpose: flag and control register of an rtc inside a memory-mapped part
// Assumes: bus pins are synchronised here; events come from on-chip logic
// Notes:   the oscillator-stopped flag lives in retained storage outside
//
// Summary of operation
// - watchdog reaching zero sets its flag
// - reading register or power up clears event flags
// - unmasked alarm match sets alarm flag
// - supply below threshold sets power-drop flag
// - oscillator dead after 5 ms sets stopped flag
// - stopped flag retained, cleared only by software
// - calibration bit drives 512 Hz on interrupt
// - write freeze stops updates, allows register writes
// - unfreeze loads counters only if time changed
// - write freeze clears at power up
`timescale 1ns/100ps
`include "rtc_flags_defs.vh"
module rtc_flags_control_register #(
  parameter [17:0] OSC_CHECK_CYCLES = `OSC_CHECK_CYCLES
) (
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire       clk_en,
  input  wire [18:0] addr,
  input  wire [7:0] dq_in,
  output reg  [7:0] dq_out,
  output wire       dq_oe,
  input  wire       ce_b,
  input  wire       oe_b,
  input  wire       we_b,
  input  wire       watchdog_zero,
  input  wire       alarm_match,
  input  wire       supply_low,
  input  wire       osc_enabled,
  input  wire       osc_running,
  input  wire       osc_flag_retained,
  output wire       osc_flag_store,
  input  wire       time_changed,
  input  wire       irq_normal,
  output wire       irq_out,
  output wire       updates_frozen,
  output wire       holding_frozen,
  output reg        load_counters
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  wire [2:0] strobes_s;
  wire       ce_s;
  wire       oe_s;
  wire       we_s;
  wire [18:0] addr_s;
  wire [7:0] din_s;

  bus_sync #(.WIDTH(3)) u_strobe_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .d_async ({~ce_b, ~oe_b, ~we_b}),
    .q_sync  (strobes_s)
  );

  bus_sync #(.WIDTH(27)) u_data_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .d_async ({addr, dq_in}),
    .q_sync  ({addr_s, din_s})
  );

  assign ce_s = strobes_s[2];
  assign oe_s = strobes_s[1];
  assign we_s = strobes_s[0];

  ////////////////////////////////////////////////////////////////////////
  // access decode
  wire hit     = ce_s && (addr_s == `RTC_FLAG_CTRL_ADDR);
  wire rd_act  = hit && oe_s && !we_s;
  wire wr_act  = hit && we_s;

  // the tracker remembers last cycle's access so both ends of a strobe are seen
  localparam [1:0] ACC_IDLE  = 2'b00;
  localparam [1:0] ACC_READ  = 2'b01;
  localparam [1:0] ACC_WRITE = 2'b10;

  reg  [1:0] acc_state_reg;
  reg  [1:0] acc_state_next;
  reg  [7:0] wr_data_reg;

  always @* begin
    acc_state_next = acc_state_reg;
    case (acc_state_reg)
      ACC_IDLE: begin
        if (rd_act) begin
          acc_state_next = ACC_READ;
        end else if (wr_act) begin
          acc_state_next = ACC_WRITE;
        end
      end
      ACC_READ: begin
        if (!rd_act) begin
          acc_state_next = wr_act ? ACC_WRITE : ACC_IDLE;
        end
      end
      ACC_WRITE: begin
        if (!wr_act) begin
          acc_state_next = rd_act ? ACC_READ : ACC_IDLE;
        end
      end
      default: begin
        acc_state_next = ACC_IDLE;
      end
    endcase
  end

  // clear on the end of a read so the driven value stays stable meanwhile
  wire rd_done  = (acc_state_reg == ACC_READ) && !rd_act;
  wire rd_start = rd_act && (acc_state_reg != ACC_READ);
  // write data taken at the end of the write strobe, as an sram latches it
  wire wr_done  = (acc_state_reg == ACC_WRITE) && !wr_act;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      acc_state_reg <= ACC_IDLE;
    end else if (clk_en) begin
      acc_state_reg <= acc_state_next;
    end
  end

  // the last sample inside the strobe is kept: the host turns data around with the strobe
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_data_reg <= 8'h00;
    end else if (clk_en) begin
      if (wr_act) begin
        wr_data_reg <= din_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event flags
  reg watchdog_expired_flag;
  reg alarm_match_flag;
  reg power_drop_flag;
  reg oscillator_stopped_flag;
  reg osc_loaded_reg;

  // a set in the clearing cycle wins so no event is lost
  function sticky_next;
    input cur;
    input set;
    input clr;
    begin
      if (set) begin
        sticky_next = 1'b1;
      end else if (clr) begin
        sticky_next = 1'b0;
      end else begin
        sticky_next = cur;
      end
    end
  endfunction

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_expired_flag <= 1'b0;
    end else if (clk_en) begin
      watchdog_expired_flag <= sticky_next(watchdog_expired_flag, watchdog_zero, rd_done);
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      alarm_match_flag <= 1'b0;
    end else if (clk_en) begin
      alarm_match_flag <= sticky_next(alarm_match_flag, alarm_match, rd_done);
    end
  end

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      power_drop_flag <= 1'b0;
    end else if (clk_en) begin
      power_drop_flag <= sticky_next(power_drop_flag, supply_low, rd_done);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator check window after power up
  reg [17:0] osc_count_reg;
  reg        osc_window_reg;
  wire       osc_fail_now = osc_window_reg && (osc_count_reg == OSC_CHECK_CYCLES - 18'd1)
                            && osc_enabled && !osc_running;
  // only the captured write data counts; the pins already show the next bus value
  wire       osc_clear    = wr_done && !wr_data_reg[`FLD_OSC_STOPPED];

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      osc_count_reg           <= 18'd0;
      osc_window_reg          <= 1'b1;
      osc_loaded_reg          <= 1'b0;
      oscillator_stopped_flag <= 1'b0;
    end else if (clk_en) begin
      if (!osc_loaded_reg) begin
        // retained value is picked up after reset release, never under reset
        oscillator_stopped_flag <= osc_flag_retained;
        osc_loaded_reg          <= 1'b1;
      end else begin
        oscillator_stopped_flag <= sticky_next(oscillator_stopped_flag, osc_fail_now, osc_clear);
      end
      if (osc_window_reg) begin
        if (osc_count_reg == OSC_CHECK_CYCLES - 18'd1) begin
          osc_window_reg <= 1'b0;
        end else begin
          osc_count_reg <= osc_count_reg + 18'd1;
        end
      end
    end
  end

  assign osc_flag_store = oscillator_stopped_flag;

  ////////////////////////////////////////////////////////////////////////
  // control bits
  reg cal_bit;
  reg write_freeze_bit;
  reg read_freeze_bit;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cal_bit          <= 1'b0;
      write_freeze_bit <= 1'b0;
      read_freeze_bit  <= 1'b0;
    end else if (clk_en) begin
      if (wr_done) begin
        cal_bit          <= wr_data_reg[`FLD_CAL];
        write_freeze_bit <= wr_data_reg[`FLD_WRITE_FREEZE];
        read_freeze_bit  <= wr_data_reg[`FLD_READ_FREEZE];
      end
    end
  end

  // the old freeze bit is read here, so a write that leaves it low loads nothing
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      load_counters <= 1'b0;
    end else if (clk_en) begin
      load_counters <= wr_done && write_freeze_bit && !wr_data_reg[`FLD_WRITE_FREEZE] && time_changed;
    end
  end

  assign updates_frozen = write_freeze_bit;
  assign holding_frozen = read_freeze_bit;

  ////////////////////////////////////////////////////////////////////////
  // calibration output
  wire cal_wave;

  cal_wave_gen u_cal (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clk_en  (clk_en),
    .run     (cal_bit),
    .wave    (cal_wave)
  );

  assign irq_out = cal_bit ? cal_wave : irq_normal;

  ////////////////////////////////////////////////////////////////////////
  // read data
  wire [7:0] reg_view = {watchdog_expired_flag, alarm_match_flag, power_drop_flag,
                         oscillator_stopped_flag, 1'b0, cal_bit,
                         write_freeze_bit, read_freeze_bit};

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dq_out <= `RTC_FLAG_RESET;
    end else if (clk_en) begin
      // data is latched on read entry so the clear at read end is not seen
      if (rd_start) begin
        dq_out <= reg_view;
      end
    end
  end

  // pins are driven only once the latched value has settled
  assign dq_oe = rd_act && (acc_state_reg == ACC_READ);

endmodule

/* File: testbench/rtc_flags_assertions.sv */
// Purpose: port-level checks of the rtc flag and control register
// Assumes: bus pins pass a two-flop synchroniser before use
// Notes:   flag bits other than the stopped flag show only through reads, so the bench checks those
`timescale 1ns/100ps
module rtc_flags_checker (
  input wire clk_sys,
  input wire rst_b,
  input wire ce_b,
  input wire oe_b,
  input wire we_b,
  input wire dq_oe,
  input wire osc_flag_store,
  input wire time_changed,
  input wire irq_normal,
  input wire irq_out,
  input wire updates_frozen,
  input wire holding_frozen,
  input wire load_counters
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////
  property p_rd_oe; $rose(dq_oe) |-> $past(!ce_b && !oe_b && we_b, 3); endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("data driven without a read");
  property p_oe_idle; ce_b [*5] |-> !dq_oe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data driven while deselected");
  // the last low cycle of the strobe is four samples back
  property p_osc_clr; $fell(osc_flag_store) |-> !$past(we_b, 4); endproperty
  a_osc_clr: assert property (p_osc_clr) else $error("stopped flag cleared without a write");
  property p_frz; $changed(updates_frozen) |-> !$past(we_b, 4); endproperty
  a_frz: assert property (p_frz) else $error("write freeze moved without a write");
  property p_hold; $changed(holding_frozen) |-> !$past(we_b, 4); endproperty
  a_hold: assert property (p_hold) else $error("read freeze moved without a write");
  property p_load; load_counters |-> !updates_frozen && $past(updates_frozen, 2) && $past(time_changed, 2); endproperty
  a_load: assert property (p_load) else $error("counter load without unfreeze and change");
  property p_load_once; load_counters |=> !load_counters; endproperty
  a_load_once: assert property (p_load_once) else $error("counter load longer than one cycle");
  property p_rst; $rose(rst_b) |-> irq_out == irq_normal && !updates_frozen && !holding_frozen; endproperty
  a_rst: assert property (p_rst) else $error("control bits not cleared by reset");
  c_load: cover property (load_counters);
  c_read: cover property ($rose(dq_oe));
  c_osc: cover property ($fell(osc_flag_store));
endmodule
bind rtc_flags_control_register rtc_flags_checker chk_u (.clk_sys, .rst_b, .ce_b, .oe_b, .we_b, .dq_oe,
  .osc_flag_store, .time_changed, .irq_normal, .irq_out, .updates_frozen, .holding_frozen, .load_counters);

/* File: testbench/host_bus_model.sv */
// Purpose: host processor on the asynchronous memory bus
// Assumes: strobes held six clocks, at least five clocks between accesses
// Notes:   pins change on the falling clock edge only
`timescale 1ns/100ps
module host_bus_model (
  input  wire        clk_sys,
  input  wire [7:0]  dq_out,
  input  wire        dq_oe,
  output reg  [18:0] addr,
  output wire [7:0]  dq_in,
  output reg         ce_b,
  output reg         oe_b,
  output reg         we_b
);
  reg [7:0] d;
  // released bus shows the inverse of the last value, so it differs from the value just sent
  assign dq_in = dq_oe ? dq_out : d;
  initial begin
    addr = 19'h00000;
    d = 8'h00;
    ce_b = 1'b1;
    oe_b = 1'b1;
    we_b = 1'b1;
  end
  task acc(input wr, input [18:0] a, input [7:0] v, output [8:0] q);
    begin
      @(negedge clk_sys);
      addr = a;
      d = v;
      ce_b = 1'b0;
      oe_b = wr;
      we_b = !wr;
      repeat (6) @(negedge clk_sys);
      q = {dq_oe, dq_out};
      ce_b = 1'b1;
      oe_b = 1'b1;
      we_b = 1'b1;
      d = ~d;
      repeat (4) @(negedge clk_sys);
    end
  endtask
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the rtc flag and control register
// Assumes: host model paces every bus cycle
// Notes:   a short oscillator window keeps the run brief
`timescale 1ns/100ps
`include "rtc_flags_defs.vh"
module tb_top;
  reg         clk_sys, rst_b, watchdog_zero, alarm_match, supply_low, b;
  reg         osc_enabled, osc_running, osc_flag_retained, time_changed, irq_normal;
  reg  [7:0]  m, v;
  reg  [8:0]  q;
  wire [18:0] addr;
  wire [7:0]  dq_in, dq_out;
  wire        dq_oe, ce_b, oe_b, we_b, osc_flag_store, irq_out, updates_frozen, holding_frozen, load_counters;
  integer     n_fail, total_checks, i, k, n, n_load;
  rtc_flags_control_register #(.OSC_CHECK_CYCLES(18'd20)) dut_u (.clk_sys, .rst_b, .clk_en(1'b1), .addr, .dq_in,
    .dq_out, .dq_oe, .ce_b, .oe_b, .we_b, .watchdog_zero, .alarm_match, .supply_low, .osc_enabled, .osc_running,
    .osc_flag_retained, .osc_flag_store, .time_changed, .irq_normal, .irq_out, .updates_frozen, .holding_frozen,
    .load_counters);
  host_bus_model host_u (.clk_sys, .dq_out, .dq_oe, .addr, .dq_in, .ce_b, .oe_b, .we_b);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (load_counters === 1'b1) n_load <= n_load + 1;
  ////////////////////////////////////////////////////////////////
  task chk8(input string nm, input [7:0] e, input [7:0] s);
    begin
      total_checks = total_checks + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("wrong value %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task chk32(input string nm, input [31:0] e, input [31:0] s);
    begin
      total_checks = total_checks + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("wrong value %s expected %0d seen %0d", nm, e, s);
      end
    end
  endtask
  function [31:0] half_period(input [31:0] clk_hz, input [31:0] f_hz);
    half_period = clk_hz / (2 * f_hz);
  endfunction
  task rd_chk(input [7:0] e);
    begin
      host_u.acc(1'b0, `RTC_FLAG_CTRL_ADDR, 8'h00, q);
      chk8("flags", e, q[7:0]);
      chk8("oe", 8'h01, {7'h00, q[8]});
      chk8("store", {7'h00, e[4]}, {7'h00, osc_flag_store});
    end
  endtask
  // flags 7..5 never persist in the model: every check reads them away
  function [7:0] exp_wr(input [7:0] o, input [7:0] d);
    exp_wr = {3'b000, o[4] & d[4], 1'b0, d[2:0]};
  endfunction
  task wr(input [7:0] d);
    begin
      host_u.acc(1'b1, `RTC_FLAG_CTRL_ADDR, d, q);
      m = exp_wr(m, d);
    end
  endtask
  task do_reset;
    begin
      rst_b = 1'b0;
      repeat (8) @(negedge clk_sys);
      rst_b = 1'b1;
      repeat (2) @(negedge clk_sys);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {watchdog_zero, alarm_match, supply_low, time_changed, irq_normal} = 5'h00;
    {osc_enabled, osc_running, osc_flag_retained} = 3'h7;
    n_fail = 0;
    total_checks = 0;
    n_load = 0;
    m = 8'h10;
    k = $urandom(87);
    do_reset;
    rd_chk(m);
    $display("reset test done");
    for (i = 0; i < 8; i = i + 1) begin
      k = (i < 4) ? i : $urandom % 4;
      v = (k == 3) ? 8'hE0 : 8'h80 >> k;
      @(negedge clk_sys);
      {watchdog_zero, alarm_match, supply_low} = v[7:5];
      @(negedge clk_sys);
      {watchdog_zero, alarm_match, supply_low} = 3'h0;
      rd_chk(m | v);
      rd_chk(m);
    end
    // an event in the very cycle a read clears the flags must survive the clear
    fork
      rd_chk(m);
      begin
        repeat (9) @(negedge clk_sys);
        watchdog_zero = 1'b1;
        @(negedge clk_sys);
        watchdog_zero = 1'b0;
      end
    join
    rd_chk(m | 8'h80);
    rd_chk(m);
    $display("event test done");
    for (i = 0; i < 6; i = i + 1) begin
      k = $urandom;
      v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : k[7:0];
      wr(v);
      rd_chk(m);
      chk8("frozen", {6'h00, m[1:0]}, {6'h00, updates_frozen, holding_frozen});
      b = irq_out;
      irq_normal = ~irq_normal;
      @(negedge clk_sys);
      chk8("irq", {7'h00, m[2] ? b : irq_normal}, {7'h00, irq_out});
    end
    host_u.acc(1'b0, 19'h7FFEF, 8'h00, q);
    chk8("oe", 8'h00, {7'h00, q[8]});
    host_u.acc(1'b1, 19'h7FFF8, ~m, q);
    rd_chk(m);
    for (i = 0; i < 2; i = i + 1) begin
      time_changed = (i == 0);
      wr(8'h02);
      n = n_load;
      wr(8'h00);
      rd_chk(m);
      chk8("loads", {7'h00, time_changed}, 8'(n_load - n));
    end
    // one full high phase of the calibration wave, counted in clock cycles
    irq_normal = 1'b0;
    wr(8'h04);
    for (n = 0; n < 50000 && irq_out !== 1'b1; n = n + 1) @(negedge clk_sys);
    if (n == 50000) n_fail = n_fail + 1;
    for (n = 0; n < 50000 && irq_out === 1'b1; n = n + 1) @(negedge clk_sys);
    chk32("cal half period", half_period(`CLK_HZ, `CAL_FREQ_HZ), n);
    $display("control test done");
    osc_running = 1'b0;
    osc_flag_retained = 1'b0;
    do_reset;
    repeat (30) @(negedge clk_sys);
    m = 8'h10;
    rd_chk(m);
    $display("oscillator test done");
    report_and_stop;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_fail = n_fail + 1;
    report_and_stop;
  end
endmodule
